// ==== lbb_top.sv ====
// led bank brightness and configuration register bank on a two-wire link
// assumes synchronous pins; sda is open drain, resolved outside
`default_nettype none

module lbb_top
  import lbb_pkg::*;
#(
  parameter int         STEP_CYC = STEP_CYC_DEF,
  parameter logic [6:0] DEV_ADDR = 7'h36
)
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             ce,
  // two-wire link
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe,
  // sink mapping and feedback
  output logic      [7:0]       hv_sink_map,
  output logic      [7:0]       lv_sink_map,
  output logic      [7:0]       hv_fb_en,
  output logic      [7:0]       lv_fb_en,
  // bank control
  output logic      [7:0]       bank_en,
  output logic      [7:0]       pattern_en,
  output logic                  map_exponential,
  // boost
  output logic      [1:0]       overvoltage_threshold,
  output logic                  switching_frequency_1mhz,
  // pulse input
  output logic                  pwm_zero_detect,
  output logic                  pwm_active_high,
  output logic                  pwm_bank_b,
  output logic                  pwm_bank_a,
  // indicator banks
  output logic      [7:0]       fs_current_c,
  output logic      [7:0]       fs_current_f,
  output logic      [7:0]       ramp_c,
  output logic      [7:0]       ramp_d,
  output logic      [7:0]       ramp_e,
  output logic      [7:0]       ramp_f,
  output logic      [7:0]       level_c,
  output logic      [7:0]       level_f,
  // bank a dimming
  output logic      [LVL_W-1:0] level_a
);

  logic         scl_rise, scl_fall, start, stop, sda_in;
  lbb_link_st_t st_r;
  logic [3:0]   cnt_r;
  logic [7:0]   sh_r, ptr_r, wr_addr_r, wr_data_r, rd_data;
  logic         rw_r, wr_stb_r, oe_r;
  logic [7:0]   reg_r [NREG];
  logic [FINE_W-1:0] fine_r;
  logic [LVL_W-1:0]  target_a;

  lbb_link_edge u_edge (
    .clock    (clock),
    .rst      (rst),
    .ce       (ce),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .scl_rise (scl_rise),
    .scl_fall (scl_fall),
    .start    (start),
    .stop     (stop),
    .sda_q    (sda_in)
  );

  // link byte machine
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_r      <= ST_IDLE;
      cnt_r     <= 4'h0;
      sh_r      <= 8'h00;
      rw_r      <= 1'b0;
      ptr_r     <= 8'h00;
      oe_r      <= 1'b0;
      wr_stb_r  <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end
    else if (ce)
    begin
      wr_stb_r <= 1'b0;
      if (stop)
      begin
        st_r <= ST_IDLE;
        oe_r <= 1'b0;
      end
      else if (start)
      begin
        st_r  <= ST_ADDR;
        cnt_r <= 4'h0;
        oe_r  <= 1'b0;
      end
      else if (st_r == ST_RDATA)
      begin
        if (scl_rise)
        begin
          if (cnt_r == BIT_ACK)
          begin
            if (sda_in)
              st_r <= ST_IDLE;
            else
            begin
              cnt_r <= 4'h0;
              ptr_r <= ptr_r + 8'h01;
            end
          end
          else
            cnt_r <= cnt_r + 4'h1;
        end
        else if (scl_fall)
          oe_r <= (cnt_r < BIT_ACK) ? ~rd_data[3'h7 - cnt_r[2:0]] : 1'b0;
      end
      else if (st_r != ST_IDLE)
      begin
        if (scl_rise && cnt_r < BIT_ACK)
        begin
          sh_r  <= {sh_r[6:0], sda_in};
          cnt_r <= cnt_r + 4'h1;
        end
        else if (scl_fall && cnt_r == BIT_ACK)
        begin
          cnt_r <= BIT_DONE;
          unique case (st_r)
            ST_ADDR:
            begin
              if (sh_r[7:1] == DEV_ADDR)
              begin
                oe_r <= 1'b1;
                rw_r <= sh_r[0];
              end
              else
                st_r <= ST_IDLE;
            end
            ST_PTR:
            begin
              ptr_r <= sh_r;
              oe_r  <= 1'b1;
            end
            ST_WDATA:
            begin
              wr_stb_r  <= 1'b1;
              wr_addr_r <= ptr_r;
              wr_data_r <= sh_r;
              ptr_r     <= ptr_r + 8'h01;
              oe_r      <= 1'b1;
            end
            default:
              st_r <= ST_IDLE;
          endcase
        end
        else if (scl_fall && cnt_r == BIT_DONE)
        begin
          cnt_r <= 4'h0;
          oe_r  <= 1'b0;
          if (st_r == ST_ADDR && rw_r)
          begin
            st_r <= ST_RDATA;
            oe_r <= ~rd_data[7];
          end
          else if (st_r == ST_ADDR)
            st_r <= ST_PTR;
          else if (st_r == ST_PTR)
            st_r <= ST_WDATA;
        end
      end
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = oe_r;

  // register slots, reset to defaults
  for (genvar g = 0; g < NREG; g++)
  begin : g_reg
    always_ff @(posedge clock)
    begin
      if (rst)
        reg_r[g] <= RST_TAB[g];
      else if (ce && wr_stb_r && wr_addr_r == ADDR_TAB[g])
        reg_r[g] <= wr_data_r;
    end
  end

  // readback; unmapped offsets read zero
  always_comb
  begin
    rd_data = 8'h00;
    for (int i = 0; i < NREG; i++)
      if (ptr_r == ADDR_TAB[i])
        rd_data = reg_r[i];
  end

  // low byte held until high byte written
  always_ff @(posedge clock)
  begin
    if (rst)
      fine_r <= '0;
    else if (ce && wr_stb_r && wr_addr_r == A_BR_A_HI)
      fine_r <= reg_r[I_BR_LO][FINE_W-1:0];
  end

  assign target_a = {reg_r[I_BR_HI], fine_r};

  lbb_dimmer #(
    .STEP_CYC (STEP_CYC)
  ) u_dim (
    .clock  (clock),
    .rst    (rst),
    .ce     (ce),
    .target (target_a),
    .level  (level_a)
  );

  // configuration fields
  assign hv_sink_map = reg_r[I_HV_MAP];
  assign lv_sink_map = reg_r[I_LV_MAP];
  assign hv_fb_en    = reg_r[I_HV_FB];
  assign lv_fb_en    = reg_r[I_LV_FB];
  assign bank_en     = reg_r[I_BANK];
  assign pattern_en  = reg_r[I_PATT];
  assign map_exponential = MAP_EXP;
  assign overvoltage_threshold =
    reg_r[I_BOOST][BOOST_THR_LSB +: 2];
  assign switching_frequency_1mhz = reg_r[I_BOOST][BOOST_FREQ_BIT];
  assign pwm_zero_detect = reg_r[I_PULSE][PWM_ZD_BIT];
  assign pwm_active_high = reg_r[I_PULSE][PWM_POL_BIT];
  assign pwm_bank_b      = reg_r[I_PULSE][PWM_B_BIT];
  assign pwm_bank_a      = reg_r[I_PULSE][PWM_A_BIT];
  assign fs_current_c = reg_r[I_FS_C];
  assign fs_current_f = reg_r[I_FS_F];
  assign ramp_c = reg_r[I_RAMP_C];
  assign ramp_d = reg_r[I_RAMP_C + 1];
  assign ramp_e = reg_r[I_RAMP_C + 2];
  assign ramp_f = reg_r[I_RAMP_C + 3];
  assign level_c = reg_r[I_BR_C];
  assign level_f = reg_r[I_BR_F];

  // checks
  property p_lo_held;
    @(posedge clock) disable iff (rst)
    (ce && wr_stb_r && wr_addr_r == A_BR_A_LO) |=> $stable(target_a);
  endproperty
  a_lo_held: assert property (p_lo_held)
    else $error("low brightness byte applied early");

  property p_hi_apply;
    @(posedge clock) disable iff (rst)
    (ce && wr_stb_r && wr_addr_r == A_BR_A_HI) |=>
      target_a == {$past(wr_data_r), $past(reg_r[I_BR_LO][2:0])};
  endproperty
  a_hi_apply: assert property (p_hi_apply)
    else $error("high byte did not apply held low bits");

  property p_defaults;
    @(posedge clock) disable iff (rst)
    $fell(rst) |-> (fs_current_c == FS_DEFAULT && ramp_f == RAMP_DEFAULT
      && map_exponential && level_a == 11'h000);
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("wrong defaults after reset");

  property p_hv_map;
    @(posedge clock) disable iff (rst)
    (ce && wr_stb_r && wr_addr_r == A_HV_MAP) |=>
      hv_sink_map == $past(wr_data_r);
  endproperty
  a_hv_map: assert property (p_hv_map)
    else $error("sink map not stored");

  property p_lv_fb;
    @(posedge clock) disable iff (rst)
    (ce && wr_stb_r && wr_addr_r == A_LV_FB) |=>
      lv_fb_en == $past(wr_data_r) && $stable(hv_fb_en);
  endproperty
  a_lv_fb: assert property (p_lv_fb)
    else $error("feedback enables wrong");

  property p_boost;
    @(posedge clock) disable iff (rst)
    (ce && wr_stb_r && wr_addr_r == A_BOOST && wr_data_r == 8'h04) |=>
      overvoltage_threshold == THR_32V && !switching_frequency_1mhz;
  endproperty
  a_boost: assert property (p_boost)
    else $error("boost decode wrong");

  property p_pulse;
    @(posedge clock) disable iff (rst)
    (ce && wr_stb_r && wr_addr_r == A_PULSE && wr_data_r == 8'h0d) |=>
      pwm_zero_detect && pwm_active_high && !pwm_bank_b && pwm_bank_a;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("pulse input decode wrong");

  property p_bank_en;
    @(posedge clock) disable iff (rst)
    (ce && wr_stb_r && wr_addr_r == A_BANK_EN) |=>
      bank_en == $past(wr_data_r) ##1 bank_en == $past(bank_en);
  endproperty
  a_bank_en: assert property (p_bank_en)
    else $error("bank enables not stored");

  property p_fs;
    @(posedge clock) disable iff (rst)
    (ce && wr_stb_r && wr_addr_r == A_FS_F) |=>
      fs_current_f == $past(wr_data_r) && $stable(fs_current_c);
  endproperty
  a_fs: assert property (p_fs)
    else $error("full-scale code not stored");

  property p_ramp;
    @(posedge clock) disable iff (rst)
    (ce && wr_stb_r && wr_addr_r == A_RAMP_E) |=>
      ramp_e == $past(wr_data_r) && $stable(ramp_d);
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("ramp code not stored");

  property p_patt;
    @(posedge clock) disable iff (rst)
    (ce && wr_stb_r && wr_addr_r == A_PATT_EN) |=>
      pattern_en == $past(wr_data_r);
  endproperty
  a_patt: assert property (p_patt)
    else $error("pattern enables not stored");

endmodule

`default_nettype wire

// ==== lbb_pkg.sv ====
// constants for the led bank brightness and configuration register bank
// assumes a 100 MHz clock and byte-wide registers on a two-wire link
`default_nettype none

package lbb_pkg;

  // clock and dimming timing
  localparam int CLK_MHZ      = 100;
  localparam int RAMP_US      = 2048;
  localparam int LSB_STEPS    = 8;
  localparam int STEP_CYC_DEF = RAMP_US * CLK_MHZ / LSB_STEPS;
  localparam int LVL_W        = 11;
  localparam int FINE_W       = 3;

  // register offsets
  localparam logic [7:0] A_HV_MAP   = 8'h10;
  localparam logic [7:0] A_LV_MAP   = 8'h11;
  localparam logic [7:0] A_RAMP_C   = 8'h14;
  localparam logic [7:0] A_RAMP_D   = 8'h15;
  localparam logic [7:0] A_RAMP_E   = 8'h16;
  localparam logic [7:0] A_RAMP_F   = 8'h17;
  localparam logic [7:0] A_FS_C     = 8'h22;
  localparam logic [7:0] A_FS_F     = 8'h25;
  localparam logic [7:0] A_HV_FB    = 8'h28;
  localparam logic [7:0] A_LV_FB    = 8'h29;
  localparam logic [7:0] A_BANK_EN  = 8'h2b;
  localparam logic [7:0] A_PATT_EN  = 8'h2c;
  localparam logic [7:0] A_BOOST    = 8'h2d;
  localparam logic [7:0] A_PULSE    = 8'h2f;
  localparam logic [7:0] A_BR_A_LO  = 8'h40;
  localparam logic [7:0] A_BR_A_HI  = 8'h41;
  localparam logic [7:0] A_BR_C     = 8'h44;
  localparam logic [7:0] A_BR_F     = 8'h47;

  // storage slots
  localparam int NREG     = 18;
  localparam int I_HV_MAP = 0;
  localparam int I_LV_MAP = 1;
  localparam int I_RAMP_C = 2;
  localparam int I_FS_C   = 6;
  localparam int I_FS_F   = 7;
  localparam int I_HV_FB  = 8;
  localparam int I_LV_FB  = 9;
  localparam int I_BANK   = 10;
  localparam int I_PATT   = 11;
  localparam int I_BOOST  = 12;
  localparam int I_PULSE  = 13;
  localparam int I_BR_LO  = 14;
  localparam int I_BR_HI  = 15;
  localparam int I_BR_C   = 16;
  localparam int I_BR_F   = 17;

  // reset codes: full-scale code for 20.2 mA, ramp code for 2048 us
  localparam logic [7:0] FS_DEFAULT   = 8'h13;
  localparam logic [7:0] RAMP_DEFAULT = 8'h00;
  localparam logic       MAP_EXP      = 1'b1;

  localparam logic [7:0] ADDR_TAB [NREG] = '{
    A_HV_MAP, A_LV_MAP, A_RAMP_C, A_RAMP_D, A_RAMP_E, A_RAMP_F,
    A_FS_C, A_FS_F, A_HV_FB, A_LV_FB, A_BANK_EN, A_PATT_EN,
    A_BOOST, A_PULSE, A_BR_A_LO, A_BR_A_HI, A_BR_C, A_BR_F};
  localparam logic [7:0] RST_TAB [NREG] = '{
    8'h00, 8'h00, RAMP_DEFAULT, RAMP_DEFAULT, RAMP_DEFAULT, RAMP_DEFAULT,
    FS_DEFAULT, FS_DEFAULT, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // field positions
  localparam int BOOST_FREQ_BIT = 0;
  localparam int BOOST_THR_LSB  = 1;
  localparam int PWM_A_BIT      = 0;
  localparam int PWM_B_BIT      = 1;
  localparam int PWM_POL_BIT    = 2;
  localparam int PWM_ZD_BIT     = 3;
  localparam logic [1:0] THR_24V = 2'h1;
  localparam logic [1:0] THR_32V = 2'h2;

  // link byte machine
  localparam logic [3:0] BIT_ACK  = 4'h8;
  localparam logic [3:0] BIT_DONE = 4'h9;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_PTR   = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100
  } lbb_link_st_t;

endpackage

`default_nettype wire

// ==== lbb_link_edge.sv ====
// samples the two-wire link pins and flags edges, start and stop
// assumes the pins are synchronous to clock and idle high
`default_nettype none

module lbb_link_edge
  import lbb_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic ce,
  // pins
  input  wire logic scl_i,
  input  wire logic sda_i,
  // events
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start,
  output logic      stop,
  output logic      sda_q
);

  logic scl_r, sda_r, scl_p_r, sda_p_r;

  // current and previous samples
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      scl_r   <= 1'b1;
      sda_r   <= 1'b1;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end
    else if (ce)
    begin
      scl_r   <= scl_i;
      sda_r   <= sda_i;
      scl_p_r <= scl_r;
      sda_p_r <= sda_r;
    end
  end

  assign scl_rise = scl_r & ~scl_p_r;
  assign scl_fall = ~scl_r & scl_p_r;
  assign start    = scl_r & scl_p_r & sda_p_r & ~sda_r;
  assign stop     = scl_r & scl_p_r & ~sda_p_r & sda_r;
  assign sda_q    = sda_r;

endmodule

`default_nettype wire

// ==== lbb_dimmer.sv ====
// walks an 11-bit level one code at a time toward its target
// assumes the target is held stable by the register bank
`default_nettype none

module lbb_dimmer
  import lbb_pkg::*;
#(
  parameter int STEP_CYC = STEP_CYC_DEF
)
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             ce,
  // level
  input  wire logic [LVL_W-1:0] target,
  output logic      [LVL_W-1:0] level
);

  localparam int CW = $clog2(STEP_CYC + 1);

  logic [CW-1:0]    cnt_r;
  logic [LVL_W-1:0] level_r;

  // step pacing
  always_ff @(posedge clock)
  begin
    if (rst)
      cnt_r <= '0;
    else if (ce)
      cnt_r <= (cnt_r == CW'(STEP_CYC - 1)) ? '0 : cnt_r + 1'b1;
  end

  // fine codes fill in between coarse levels
  always_ff @(posedge clock)
  begin
    if (rst)
      level_r <= '0;
    else if (ce && cnt_r == CW'(STEP_CYC - 1))
    begin
      if (level_r < target)
        level_r <= level_r + 1'b1;
      else if (level_r > target)
        level_r <= level_r - 1'b1;
    end
  end

  assign level = level_r;

  property p_one_code;
    @(posedge clock) disable iff (rst)
    1'b1 |=> (level == $past(level) || level == $past(level) + 11'h001
      || level == $past(level) - 11'h001);
  endproperty
  a_one_code: assert property (p_one_code)
    else $error("level moved by more than one code");

endmodule

`default_nettype wire

// ==== lbb_host.sv ====
// two-wire host model driving the register link of the bank
// assumes an open-drain data wire with a pull-up resolved by the bench
`default_nettype none

module lbb_host
  import lbb_pkg::*;
#(
  parameter logic [6:0] DEV = 7'h36,
  parameter int         PH  = 4
)
(
  // clock
  input  wire logic clock,
  // link pins
  output logic      scl,
  output logic      sda_pd,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    scl    = 1'b1;
    sda_pd = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask

  // one bit: data moves mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    scl <= 1'b0;
    hold(2);
    sda_pd <= ~b;
    hold(2);
    scl <= 1'b1;
    hold(2);
    s = sda;
    hold(2);
  endtask

  task automatic start;
    logic s;
    bit_io(1'b1, s);
    sda_pd <= 1'b1;
    hold(PH);
  endtask

  task automatic stop;
    logic s;
    bit_io(1'b0, s);
    sda_pd <= 1'b0;
    hold(PH);
  endtask

  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask

  // n copies of d from ptr on; pointer auto-increments
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
                    input logic [7:0] d, input int n, output logic ok);
    logic a;
    start();
    put({dev, 1'b0}, ok);
    put(ptr, a);
    ok &= a;
    repeat (n)
    begin
      put(d, a);
      ok &= a;
    end
    stop();
  endtask

  task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
    logic a;
    start();
    put({DEV, 1'b0}, a);
    put(ptr, a);
    start();
    put({DEV, 1'b1}, a);
    get(1'b1, d);
    stop();
  endtask
endmodule

`default_nettype wire

// ==== lbb_top_tb.sv ====
// self-checking bench for the led bank register block
// assumes the host model drives the link; data wire has a pull-up
`default_nettype none

module lbb_top_tb
  import lbb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         STEP = 4;
  localparam logic [6:0] DEV  = 7'h36; // arbitrary address
  localparam int         NR   = 15;
  // rows {offset, data}; c and f brightness before the last bank and pattern enables
  localparam logic [15:0] ROWS [NR] = '{
    16'h1004, 16'h2803, 16'h2d04, 16'h2d03, 16'h2f0d, 16'h2b01, 16'h1120,
    16'h2200, 16'h2500, 16'h291f, 16'h44a5, 16'h47a5, 16'h2b25, 16'h1136,
    16'h2cfc};

  logic             clock, rst, ce, sda_o, sda_oe, host_pd, scl_w, sda_w;
  logic [7:0]       hv_sink_map, lv_sink_map, hv_fb_en, lv_fb_en, bank_en;
  logic [7:0]       pattern_en, fs_current_c, fs_current_f, level_c, level_f;
  logic [7:0]       ramp_c, ramp_d, ramp_e, ramp_f, a, d, rdat;
  logic [1:0]       overvoltage_threshold;
  logic             map_exponential, switching_frequency_1mhz, ok;
  logic             pwm_zero_detect, pwm_active_high, pwm_bank_b, pwm_bank_a;
  logic [LVL_W-1:0] level_a, lvl_hold;
  int               error_cnt, compares;

  assign sda_w = ~(host_pd | (sda_oe & ~sda_o));

  lbb_top #(.STEP_CYC(STEP), .DEV_ADDR(DEV)) DUT (
    .clock, .rst, .ce, .scl_i(scl_w), .sda_i(sda_w), .sda_o, .sda_oe,
    .hv_sink_map, .lv_sink_map, .hv_fb_en, .lv_fb_en, .bank_en,
    .pattern_en, .map_exponential, .overvoltage_threshold,
    .switching_frequency_1mhz, .pwm_zero_detect, .pwm_active_high,
    .pwm_bank_b, .pwm_bank_a, .fs_current_c, .fs_current_f, .ramp_c,
    .ramp_d, .ramp_e, .ramp_f, .level_c, .level_f, .level_a);

  lbb_host #(.DEV(DEV), .PH(4)) u_host (
    .clock, .scl(scl_w), .sda_pd(host_pd), .sda(sda_w));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [7:0] obs(input logic [7:0] x);
    case (x)
      A_HV_MAP:  return hv_sink_map;
      A_LV_MAP:  return lv_sink_map;
      A_FS_C:    return fs_current_c;
      A_FS_F:    return fs_current_f;
      A_HV_FB:   return hv_fb_en;
      A_LV_FB:   return lv_fb_en;
      A_BANK_EN: return bank_en;
      A_PATT_EN: return pattern_en;
      A_BR_C:    return level_c;
      A_BR_F:    return level_f;
      A_BOOST:   return {5'h00, overvoltage_threshold,
                         switching_frequency_1mhz};
      A_PULSE:   return {4'h0, pwm_zero_detect, pwm_active_high,
                         pwm_bank_b, pwm_bank_a};
      default:   return 8'h00;
    endcase
  endfunction

  task automatic finish_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // bounded wait for a level, each move one code
  task automatic wait_lvl(input logic [LVL_W-1:0] e);
    logic [LVL_W-1:0] p;
    p = level_a;
    for (int i = 0; i < 4000 && level_a !== e; i++)
    begin
      @(posedge clock);
      if (level_a !== p)
        chk(level_a, (level_a > p) ? p + 11'h001 : p - 11'h001);
      p = level_a;
    end
    chk(level_a, e);
    if (level_a !== e)
      finish_test();
  endtask

  initial
  begin
    rst = 1'b1;
    ce  = 1'b1;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk(fs_current_c, FS_DEFAULT);
    chk(fs_current_f, FS_DEFAULT);
    chk(ramp_c, RAMP_DEFAULT);
    chk(map_exponential, MAP_EXP);
    chk(level_a, 11'h000);
    for (int k = 0; k < NR; k++)
    begin
      a = ROWS[k][15:8];
      d = ROWS[k][7:0];
      u_host.wr(DEV, a, d, 1, ok);
      chk(ok, 1'b1);
      chk(obs(a), d);
      u_host.rd(a, rdat);
      chk(rdat, d);
      if (a == A_BOOST)
        chk(overvoltage_threshold, d[2] ? THR_32V : THR_24V);
    end
    // ramp registers in one burst
    u_host.wr(DEV, A_RAMP_C, 8'h33, 4, ok);
    chk({ramp_c, ramp_d}, 16'h3333);
    chk({ramp_e, ramp_f}, 16'h3333);
    u_host.rd(A_RAMP_F, rdat);
    chk(rdat, 8'h33);
    // two-byte read: master ack moves the pointer on
    u_host.start();
    u_host.put({DEV, 1'b0}, ok);
    u_host.put(A_BANK_EN, ok);
    u_host.start();
    u_host.put({DEV, 1'b1}, ok);
    u_host.get(1'b0, rdat);
    chk(rdat, 8'h25);
    u_host.get(1'b1, rdat);
    chk(rdat, 8'hfc);
    u_host.stop();
    // unmapped offset and foreign device address
    u_host.wr(DEV, 8'h12, 8'haa, 1, ok);
    u_host.rd(8'h12, rdat);
    chk(rdat, 8'h00);
    u_host.wr(DEV ^ 7'h01, A_BANK_EN, 8'h00, 1, ok);
    chk(ok, 1'b0);
    chk(bank_en, 8'h25);
    // 8-bit mode: low byte zero once, then high byte
    u_host.wr(DEV, A_BR_A_LO, 8'h00, 1, ok);
    u_host.wr(DEV, A_BR_A_HI, 8'h20, 1, ok);
    chk(level_a < 11'h100, 1'b1);
    // clock enable low freezes the walk
    ce <= 1'b0;
    @(posedge clock);
    lvl_hold = level_a;
    repeat (20) @(posedge clock);
    chk(level_a, lvl_hold);
    ce <= 1'b1;
    wait_lvl(11'h100);
    // low byte held until high byte arrives
    u_host.wr(DEV, A_BR_A_LO, 8'h05, 1, ok);
    repeat (40) @(posedge clock);
    chk(level_a, 11'h100);
    u_host.rd(A_BR_A_LO, rdat);
    chk(rdat, 8'h05);
    u_host.wr(DEV, A_BR_A_HI, 8'h20, 1, ok);
    wait_lvl(11'h105);
    // downward change with both bytes rewritten
    u_host.wr(DEV, A_BR_A_LO, 8'h07, 1, ok);
    u_host.wr(DEV, A_BR_A_HI, 8'h1f, 1, ok);
    wait_lvl(11'h0ff);
    // reset in mid-run
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk(level_a, 11'h000);
    chk(bank_en, 8'h00);
    chk(fs_current_c, FS_DEFAULT);
    chk(sda_oe, 1'b0);
    chk(sda_o, 1'b0);
    finish_test();
  end
endmodule

`default_nettype wire
